// >>> hdl/ucwk_sync.sv
// Three-stage input synchroniser; a change counts when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module ucwk_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_i, // System clock.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic [WIDTH-1:0] async_i, // Pin-side levels.
  output logic [WIDTH-1:0] sync_o // Filtered levels.
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] out;
  } ucwk_sync_t;
  ucwk_sync_t st_reg, st_next;

  // Only the second stage reads the first, keeping metastability contained.
  always_comb begin
    st_next = st_reg;
    st_next.s1 = async_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.out[i] = st_reg.s3[i];
      end
    end
  end

  // Register stage.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_o = st_reg.out;
endmodule // ucwk_sync
`default_nettype wire

// >>> hdl/ucwk_top.sv
// Clock enable, transceiver control and remote wakeup logic of a USB device.
//
// Behaviour
// R1: Oscillator buffer bit gates clock to PLL.
// R2: PLL enable multiplies input by selected factor.
// R3: PLL off passes input clock unmultiplied.
// R4: Select field encodes 48/24/12/6 MHz input.
// R5: Software enables oscillator before PLL.
// R6: Core clock enable gates clock into core.
// R7: Resume detected in suspend despite transceiver off.
// R8: Software keeps transceiver control low bit set.
// R9: Control field drives transceiver enable pin.
// R10: Module enable zero applies software reset.
// R11: Wakeup bit reads one while pending/active.
// R12: Wakeup write honoured only in suspend.
// R13: Writing zero to wakeup does nothing.
// R14: Drive K state 10 ms, then clear.
// R15: Early request waits 2 ms after suspend.
// R16: Timers pause while clocks gated off.
// R17: Reserved bits 7..1 read zero.
// R18: Factors 2, 4, 8 give 48 MHz core.
`timescale 1ns/1ps
`default_nettype none
module ucwk_top #(
  parameter int IDLE_CYC = ucwk_pkg::UCWK_IDLE_CYC,
  parameter int KSTATE_CYC = ucwk_pkg::UCWK_KSTATE_CYC
) (
  input wire logic ref_clk_i, // System clock, 100 MHz.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic [7:0] addr_i, // Register byte address.
  input wire logic [15:0] wdata_i, // Write data.
  input wire logic wr_i, // Write strobe.
  input wire logic rd_i, // Read strobe.
  output logic [15:0] rdata_o, // Read data, cycle after strobe.
  input wire logic [2:0] device_state_field_i, // Device state, 1xx suspend.
  input wire logic resume_pin_i, // Resume signalling seen on the bus pin.
  output logic osc_buffer_enable_o, // Passes external clock to PLL.
  output logic pll_enable_o, // PLL running.
  output logic [3:0] pll_mult_o, // Multiplication factor to core clock.
  output logic core_clock_enable_o, // Clock gate into core.
  output logic transceiver_power_o, // Transceiver powered.
  output logic transceiver_enable_pin_o, // Output level of enable pin.
  output logic transceiver_enable_pin_oe_o, // Enable pin driven.
  output logic sie_run_o, // Serial engine allowed to run.
  output logic soft_reset_o, // Software reset held.
  output logic resume_detect_o, // Resume seen while suspended.
  output logic kstate_o // Drive K state onto the bus.
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] oper_en;
    logic wake;
    logic [31:0] cnt;
    ucwk_pkg::ucwk_state_t fsm;
    logic susp_d;
    logic [15:0] rdata;
    logic [3:0] mult;
    logic ten_pin;
    logic ten_oe;
    logic resume;
    logic kstate;
  } ucwk_top_t;
  ucwk_top_t st_reg, st_next;

  logic resume_sync;
  logic suspended;
  logic clk_run;
  logic [1:0] sel;
  logic [1:0] ten;

  // Resume pin comes from outside the clock domain.
  ucwk_sync #(
    .WIDTH(1)
  ) u_resume_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i(resume_pin_i),
    .sync_o(resume_sync)
  );

  // ----------------------------------------------------------------
  // Derived levels
  // ----------------------------------------------------------------
  // Suspend is any device state of the form 1xx.
  assign suspended = device_state_field_i[2];
  // Counting only while the core really sees a clock.
  assign clk_run = st_reg.oper_en[ucwk_pkg::UCWK_BIT_OSC_BUF] & // R16
                   st_reg.oper_en[ucwk_pkg::UCWK_BIT_CORE_CLK];
  assign sel = st_reg.oper_en[ucwk_pkg::UCWK_BIT_SEL_HI:
                              ucwk_pkg::UCWK_BIT_SEL_LO];
  assign ten = st_reg.oper_en[ucwk_pkg::UCWK_BIT_TEN_HI:
                              ucwk_pkg::UCWK_BIT_TEN_LO];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Register writes, read mux, wakeup timing and output decode.
  always_comb begin
    st_next = st_reg;
    st_next.susp_d = suspended;

    // Register writes; reserved bits are forced to zero on the way in.
    if (wr_i && addr_i == ucwk_pkg::UCWK_OFS_OPER_EN) begin
      st_next.oper_en = wdata_i & ucwk_pkg::UCWK_OPER_EN_MASK; // R17
    end

    // Wakeup sequencer; the count only advances with a running clock.
    case (st_reg.fsm)
      ucwk_pkg::UCWK_ST_IDLE: begin
        st_next.cnt = '0;
        // Only a one in suspend starts it; a zero never clears it.
        if (wr_i && addr_i == ucwk_pkg::UCWK_OFS_WAKE &&
            wdata_i[ucwk_pkg::UCWK_BIT_WAKE] && suspended) begin // R12 R13
          st_next.wake = 1'b1; // R11
          st_next.fsm = ucwk_pkg::UCWK_ST_WAIT;
        end
      end
      ucwk_pkg::UCWK_ST_WAIT: begin
        // Bus stays idle until 2 ms of suspend have passed.
        if (!suspended) begin
          st_next.cnt = '0;
        end else if (clk_run) begin // R16
          if (st_reg.cnt >= 32'(IDLE_CYC - 1)) begin // R15
            st_next.cnt = '0;
            st_next.fsm = ucwk_pkg::UCWK_ST_KOUT;
          end else begin
            st_next.cnt = st_reg.cnt + 32'h0000_0001;
          end
        end
      end
      ucwk_pkg::UCWK_ST_KOUT: begin
        if (clk_run) begin // R16
          if (st_reg.cnt >= 32'(KSTATE_CYC - 1)) begin // R14
            st_next.cnt = '0;
            st_next.wake = 1'b0;
            st_next.fsm = ucwk_pkg::UCWK_ST_IDLE;
          end else begin
            st_next.cnt = st_reg.cnt + 32'h0000_0001;
          end
        end
      end
      default: begin
        st_next.fsm = ucwk_pkg::UCWK_ST_IDLE;
      end
    endcase

    // Suspend counted from its detection: restart the idle wait on entry.
    if (suspended && !st_reg.susp_d &&
        st_reg.fsm == ucwk_pkg::UCWK_ST_WAIT) begin // R15
      st_next.cnt = '0;
    end

    // Module enable low is software reset: wakeup register back to reset.
    if (!st_reg.oper_en[ucwk_pkg::UCWK_BIT_MOD_EN]) begin // R10
      st_next.wake = ucwk_pkg::UCWK_WAKE_RESET[0];
      st_next.cnt = '0;
      st_next.fsm = ucwk_pkg::UCWK_ST_IDLE;
    end

    // Read data stand only in the cycle after the strobe.
    st_next.rdata = 16'h0000;
    if (rd_i) begin
      if (addr_i == ucwk_pkg::UCWK_OFS_OPER_EN) begin
        st_next.rdata = st_reg.oper_en; // R17
      end else if (addr_i == ucwk_pkg::UCWK_OFS_WAKE) begin
        st_next.rdata = {15'h0000, st_reg.wake}; // R11
      end else if (addr_i == ucwk_pkg::UCWK_OFS_STATUS) begin
        st_next.rdata = {12'h000, st_reg.fsm, clk_run};
      end else begin
        st_next.rdata = 16'h0000;
      end
    end

    // Multiplier: PLL or oscillator buffer off means pass-through, else factor by select.
    if (!st_reg.oper_en[ucwk_pkg::UCWK_BIT_PLL] ||
        !st_reg.oper_en[ucwk_pkg::UCWK_BIT_OSC_BUF]) begin // R1 R3
      st_next.mult = ucwk_pkg::UCWK_MUL_1;
    end else if (sel == ucwk_pkg::UCWK_SEL_24M) begin // R2 R4 R18
      st_next.mult = ucwk_pkg::UCWK_MUL_2;
    end else if (sel == ucwk_pkg::UCWK_SEL_12M) begin // R18
      st_next.mult = ucwk_pkg::UCWK_MUL_4;
    end else if (sel == ucwk_pkg::UCWK_SEL_6M) begin // R18
      st_next.mult = ucwk_pkg::UCWK_MUL_8;
    end else begin
      st_next.mult = ucwk_pkg::UCWK_MUL_1; // R4
    end

    // Enable pin: 00 floats, 01 low, 11 high; reserved 10 floats safely.
    st_next.ten_oe = (ten == ucwk_pkg::UCWK_TEN_LOW) ||
                     (ten == ucwk_pkg::UCWK_TEN_HIGH); // R9
    st_next.ten_pin = (ten == ucwk_pkg::UCWK_TEN_HIGH); // R9

    // Resume watch stays alive in suspend even with transceiver off.
    st_next.resume = suspended & resume_sync; // R7
    st_next.kstate = (st_reg.fsm == ucwk_pkg::UCWK_ST_KOUT) &&
                     st_reg.oper_en[ucwk_pkg::UCWK_BIT_MOD_EN]; // R14
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // One flop bank; every output below comes straight from it.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.oper_en <= ucwk_pkg::UCWK_OPER_EN_RESET;
      st_reg.fsm <= ucwk_pkg::UCWK_ST_IDLE;
      st_reg.mult <= ucwk_pkg::UCWK_MUL_1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Clock path enables come direct from the register bits; the factor comes from its decoded register.
  assign osc_buffer_enable_o = st_reg.oper_en[ucwk_pkg::UCWK_BIT_OSC_BUF]; // R1
  assign pll_enable_o = st_reg.oper_en[ucwk_pkg::UCWK_BIT_PLL]; // R2
  assign pll_mult_o = st_reg.mult;
  assign core_clock_enable_o = st_reg.oper_en[ucwk_pkg::UCWK_BIT_CORE_CLK]; // R6
  assign transceiver_power_o = st_reg.oper_en[ucwk_pkg::UCWK_BIT_XCVR_PWR];
  assign transceiver_enable_pin_o = st_reg.ten_pin;
  assign transceiver_enable_pin_oe_o = st_reg.ten_oe;
  // The serial engine is stopped whenever the pin floats.
  assign sie_run_o = st_reg.ten_oe; // R9
  assign soft_reset_o = ~st_reg.oper_en[ucwk_pkg::UCWK_BIT_MOD_EN]; // R10
  assign resume_detect_o = st_reg.resume;
  assign kstate_o = st_reg.kstate;
  assign rdata_o = st_reg.rdata;
endmodule // ucwk_top
`default_nettype wire

// >>> pkg/ucwk_pkg.sv
// Package of offsets, fields, reset values and timing for the clock and wakeup block.
package ucwk_pkg;
  // ----------------------------------------------------------------
  // Register offsets and decode
  // ----------------------------------------------------------------
  localparam logic [7:0] UCWK_OFS_OPER_EN = 8'h00;
  localparam logic [7:0] UCWK_OFS_WAKE = 8'h02;
  localparam logic [7:0] UCWK_OFS_STATUS = 8'h04;
  localparam int UCWK_NUM_REGS = 3;
  localparam logic [15:0] UCWK_OPER_EN_RESET = 16'h0000;
  localparam logic [15:0] UCWK_WAKE_RESET = 16'h0000;
  // ----------------------------------------------------------------
  // Field positions of the operation enable and wakeup registers
  // ----------------------------------------------------------------
  localparam int UCWK_BIT_OSC_BUF = 15;
  localparam int UCWK_BIT_PLL = 14;
  localparam int UCWK_BIT_SEL_HI = 13;
  localparam int UCWK_BIT_SEL_LO = 12;
  localparam int UCWK_BIT_CORE_CLK = 11;
  localparam int UCWK_BIT_XCVR_PWR = 10;
  localparam int UCWK_BIT_TEN_HI = 9;
  localparam int UCWK_BIT_TEN_LO = 8;
  localparam int UCWK_BIT_MOD_EN = 0;
  localparam int UCWK_BIT_WAKE = 0;
  // Writable bits of the operation enable register; 7..1 stay zero.
  localparam logic [15:0] UCWK_OPER_EN_MASK = 16'hFF01;
  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] UCWK_SEL_48M = 2'h0;
  localparam logic [1:0] UCWK_SEL_24M = 2'h2;
  localparam logic [1:0] UCWK_SEL_12M = 2'h1;
  localparam logic [1:0] UCWK_SEL_6M = 2'h3;
  localparam logic [3:0] UCWK_MUL_1 = 4'h1;
  localparam logic [3:0] UCWK_MUL_2 = 4'h2;
  localparam logic [3:0] UCWK_MUL_4 = 4'h4;
  localparam logic [3:0] UCWK_MUL_8 = 4'h8;
  localparam logic [1:0] UCWK_TEN_HIZ = 2'h0;
  localparam logic [1:0] UCWK_TEN_LOW = 2'h1;
  localparam logic [1:0] UCWK_TEN_RSVD = 2'h2;
  localparam logic [1:0] UCWK_TEN_HIGH = 2'h3;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int UCWK_CLK_MHZ = 100;
  localparam int UCWK_IDLE_MS = 2;
  localparam int UCWK_KSTATE_MS = 10;
  // Milliseconds times cycles per millisecond of the 100 MHz clock.
  localparam int UCWK_IDLE_CYC = UCWK_IDLE_MS * UCWK_CLK_MHZ * 1000;
  localparam int UCWK_KSTATE_CYC = UCWK_KSTATE_MS * UCWK_CLK_MHZ * 1000;
  // ----------------------------------------------------------------
  // Wakeup sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    UCWK_ST_IDLE = 3'b001,
    UCWK_ST_WAIT = 3'b010,
    UCWK_ST_KOUT = 3'b100
  } ucwk_state_t;
endpackage

// >>> sim/test_ucwk_top.sv
// Self-checking bench of the clock and wakeup block.
`timescale 1ns/1ps
`default_nettype none
module test_ucwk_top;
  localparam int IDLE = 20;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic rd_d = 1'b0, susp = 1'b0, res = 1'b0, rpin, kst, rdet, oe, pin;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000, rdata_o;
  logic [2:0] dsf;
  logic [3:0] mult;
  logic [3:0] mtab [4] = '{4'h1, 4'h4, 4'h2, 4'h8};
  logic [31:0] seed = 32'h20ad_8876;
  logic [15:0] expq [$];
  int errors = 0, checked = 0, cyc = 0, n, t0, g;
  ucwk_top #(.IDLE_CYC(IDLE), .KSTATE_CYC(50)) uut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .device_state_field_i(dsf), .resume_pin_i(rpin),
    .osc_buffer_enable_o(), .pll_enable_o(), .pll_mult_o(mult),
    .core_clock_enable_o(), .transceiver_power_o(),
    .transceiver_enable_pin_o(pin), .transceiver_enable_pin_oe_o(oe),
    .sie_run_o(), .soft_reset_o(), .resume_detect_o(rdet), .kstate_o(kst));
  ucwk_host_model u_host (.ref_clk_i(ref_clk_i), .suspend_i(susp),
    .resume_i(res), .kstate_i(kst), .device_state_field_o(dsf),
    .resume_pin_o(rpin));
  initial forever #5 ref_clk_i = ~ref_clk_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic report_and_stop();
    if (errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  // Each bus task sets both strobes once, so none is driven twice per step.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    rd_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    wr_i <= 1'b0;
    expq.push_back(e);
    @(posedge ref_clk_i);
  endtask
  task automatic idle(input int c);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (c) @(posedge ref_clk_i);
  endtask
  // Read data stands only in the cycle after the strobe; compare it there.
  always @(posedge ref_clk_i) begin
    rd_d <= rd_i;
    cyc <= cyc + 1;
    if (rd_d) begin
      chk("rdata", expq[0], rdata_o);
      void'(expq.pop_front());
    end
    if (cyc == 6000) begin
      errors++;
      report_and_stop();
    end
  end
  // Main sequence: registers, clock codes, wakeup timing, resets, resume.
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 16'h0000);
    rd(8'h06, 16'h0000);
    rd(8'h04, 16'h0002);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      wr(8'h00, seed[15:0]);
      rd(8'h00, seed[15:0] & ucwk_pkg::UCWK_OPER_EN_MASK);
    end
    wr(8'h00, 16'h8001);
    idle(4);
    for (int i = 0; i < 32; i++) begin
      wr(8'h00, {1'b1, i[4], i[1:0], 2'b10, i[3:2], 8'h01});
      idle(3);
      chk("mult", {12'h000, i[4] ? mtab[i[1:0]] : 4'h1}, {12'h000, mult});
      chk("pin", {14'h0000, i[2], i[2] & i[3]}, {14'h0000, oe, oe & pin});
    end
    wr(8'h00, 16'h8801);
    wr(8'h02, 16'h0001);
    rd(8'h02, 16'h0000);
    susp <= 1'b1;
    wr(8'h02, 16'h0000);
    rd(8'h02, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      susp <= 1'b0;
      idle(2);
      susp <= 1'b1;
      t0 = cyc;
      wr(8'h02, 16'h0001);
      rd(8'h02, 16'h0001);
      rd(8'h04, 16'h0005);
      g = 31 * k;
      if (k == 1) begin
        wr(8'h00, 16'h8001);
        idle(30);
        wr(8'h00, 16'h8801);
      end
      n = 0;
      while (kst !== 1'b1 && n < 500) begin
        idle(1);
        n++;
      end
      chk("idle", 16'h0001, {15'h0000, cyc - t0 >= IDLE + g && cyc - t0 <= IDLE + g + 6});
      n = 0;
      while (kst === 1'b1 && n < 500) begin
        if (n == 5) begin
          rd(8'h02, 16'h0001);
        end else begin
          idle(1);
        end
        n++;
      end
      chk("kstate", 16'h0032, n[15:0]);
      rd(8'h02, 16'h0000);
    end
    susp <= 1'b0;
    idle(2);
    susp <= 1'b1;
    wr(8'h02, 16'h0001);
    wr(8'h00, 16'h8800);
    idle(1);
    rd(8'h02, 16'h0000);
    wr(8'h00, 16'h8d01);
    wr(8'h00, 16'h8801);
    res <= 1'b1;
    idle(8);
    chk("resume", 16'h0001, {15'h0000, rdet});
    res <= 1'b0;
    idle(4);
    report_and_stop();
  end
endmodule // test_ucwk_top
`default_nettype wire

// >>> sim/ucwk_host_model.sv
// Host model: device state and resume signalling on the bus.
`timescale 1ns/1ps
`default_nettype none
module ucwk_host_model (
  input wire logic ref_clk_i, // Clock.
  input wire logic suspend_i, // Bench asks for suspend.
  input wire logic resume_i, // Bench asks for resume signalling.
  input wire logic kstate_i, // K state from the device.
  output logic [2:0] device_state_field_o, // Suspend reads 1xx.
  output logic resume_pin_o // Resume level seen by the device.
);
  logic k_d = 1'b0;
  logic woke = 1'b0;
  // The host ends suspend once a K state has finished, as a real one would.
  always_ff @(posedge ref_clk_i) begin
    k_d <= kstate_i;
    woke <= suspend_i && (woke || (k_d && !kstate_i));
  end
  assign device_state_field_o = (suspend_i && !woke) ? 3'b101 : 3'b011;
  assign resume_pin_o = resume_i;
endmodule // ucwk_host_model
`default_nettype wire

// >>> sim/ucwk_properties.sv
// Port-level assertions of the clock and wakeup block.
`timescale 1ns/1ps
`default_nettype none
module ucwk_properties #(
  parameter int KSTATE_CYC = ucwk_pkg::UCWK_KSTATE_CYC
) (
  input wire logic ref_clk_i, // Clock.
  input wire logic rst_i, // Reset.
  input wire logic [7:0] addr_i, // Address.
  input wire logic [15:0] wdata_i, // Write data.
  input wire logic wr_i, // Write strobe.
  input wire logic rd_i, // Read strobe.
  input wire logic [15:0] rdata_o, // Read data.
  input wire logic [2:0] device_state_field_i, // Device state.
  input wire logic resume_pin_i, // Resume pin.
  input wire logic osc_buffer_enable_o, // Oscillator gate.
  input wire logic pll_enable_o, // PLL on.
  input wire logic [3:0] pll_mult_o, // Factor.
  input wire logic core_clock_enable_o, // Core gate.
  input wire logic transceiver_power_o, // Power.
  input wire logic transceiver_enable_pin_o, // Pin level.
  input wire logic transceiver_enable_pin_oe_o, // Pin drive.
  input wire logic sie_run_o, // Engine run.
  input wire logic soft_reset_o, // Software reset.
  input wire logic resume_detect_o, // Resume seen.
  input wire logic kstate_o // K state.
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic [31:0] kcnt_reg;
  // K cycles are counted only while both gates pass the clock.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      kcnt_reg <= 32'h0000_0000;
    end else if (!kstate_o) begin
      kcnt_reg <= 32'h0000_0000;
    end else if (osc_buffer_enable_o && core_clock_enable_o) begin
      kcnt_reg <= kcnt_reg + 32'h0000_0001;
    end
  end
  function automatic logic [3:0] mult_of(input logic [15:0] w);
    if (!w[15] || !w[14]) return 4'h1;
    case (w[13:12])
      2'h2: return 4'h2;
      2'h1: return 4'h4;
      2'h3: return 4'h8;
      default: return 4'h1;
    endcase
  endfunction
  sequence s_wr_oper;
    wr_i && addr_i == 8'h00;
  endsequence
  // A write followed by a cycle without another one, so outputs settle.
  sequence s_settled;
    s_wr_oper ##1 !(wr_i && addr_i == 8'h00);
  endsequence
  AST_OSC_GATE: assert property (s_wr_oper |=>
    osc_buffer_enable_o == $past(wdata_i[15]) &&
    core_clock_enable_o == $past(wdata_i[11]))
    else $error("clock gate outputs differ from register");
  AST_PLL_EN: assert property (s_wr_oper |=>
    pll_enable_o == $past(wdata_i[14]) &&
    transceiver_power_o == $past(wdata_i[10]))
    else $error("pll or power output differs from register");
  AST_MULT: assert property (s_settled |=>
    pll_mult_o == mult_of($past(wdata_i, 2)))
    else $error("multiplication factor wrong");
  AST_TEN_PIN: assert property (s_settled |=>
    transceiver_enable_pin_oe_o == $past(wdata_i[8], 2) &&
    (!$past(wdata_i[8], 2) ||
    transceiver_enable_pin_o == $past(wdata_i[9], 2)))
    else $error("transceiver enable pin wrong");
  AST_SIE_RUN: assert property (s_settled |=>
    sie_run_o == $past(wdata_i[8], 2))
    else $error("engine run differs from control field");
  AST_SOFT_RST: assert property (s_wr_oper |=>
    soft_reset_o == !$past(wdata_i[0]))
    else $error("software reset differs from module enable");
  AST_RSV_ZERO: assert property (rd_i && addr_i == 8'h00 |=>
    rdata_o[7:1] == 7'h00)
    else $error("reserved bits read nonzero");
  AST_WAKE_READ: assert property (
    (rd_i && addr_i == 8'h02 && kstate_o) ##1 kstate_o |-> rdata_o[0])
    else $error("wakeup bit reads zero during K state");
  AST_KSTATE_LEN: assert property (
    $fell(kstate_o) && !soft_reset_o |-> kcnt_reg == 32'(KSTATE_CYC))
    else $error("K state length wrong");
  AST_K_SUSPEND: assert property ($rose(kstate_o) |->
    $past(device_state_field_i[2], 2))
    else $error("K state began outside suspend");
  AST_RESUME: assert property (
    (device_state_field_i[2] && resume_pin_i) [*6] |-> resume_detect_o)
    else $error("resume not detected in suspend");
endmodule // ucwk_properties
bind ucwk_top ucwk_properties #(.KSTATE_CYC(KSTATE_CYC)) u_props (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .device_state_field_i(device_state_field_i),
  .resume_pin_i(resume_pin_i), .osc_buffer_enable_o(osc_buffer_enable_o),
  .pll_enable_o(pll_enable_o), .pll_mult_o(pll_mult_o),
  .core_clock_enable_o(core_clock_enable_o),
  .transceiver_power_o(transceiver_power_o),
  .transceiver_enable_pin_o(transceiver_enable_pin_o),
  .transceiver_enable_pin_oe_o(transceiver_enable_pin_oe_o),
  .sie_run_o(sie_run_o), .soft_reset_o(soft_reset_o),
  .resume_detect_o(resume_detect_o), .kstate_o(kstate_o));
`default_nettype wire
